// >>> src/erbw_ram.sv
// byte-write ram port with ahb-lite control and status registers
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
module erbw_ram #(
    parameter int DEPTH = erbw_pkg::DEPTH_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    input  wire logic                     portClkEn,
    input  wire logic                     wrStrobe,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [35:0]              wrData,
    input  wire logic [3:0]               byteMask,
    input  wire logic                     rdStrobe,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [35:0]                   rdData
);
    import erbw_pkg::*;

    localparam int ADDR_W = $clog2(DEPTH);

    // ****************************************
    // parameter check
    // ****************************************
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("DEPTH must be a power of two, at least 2");
        end
    endgenerate

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        erbw_width_t mode;
        logic        maskUse;
        logic [15:0] wrCount;
        logic [15:0] rdCount;
        logic [35:0] rdData;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        wrPend;
        logic [1:0]  wrSel;
    } erbw_top_t;

    erbw_top_t s_r;
    erbw_top_t s_nxt;

    logic              wrEnQ;
    logic [ADDR_W-1:0] wrAddrQ;
    logic [35:0]       wrDataQ;
    logic [3:0]        maskQ;
    logic              rdEnQ;
    logic [ADDR_W-1:0] rdAddrQ;
    logic [3:0]        maskIn;
    logic [35:0]       bitEn;
    logic [35:0]       memRd;
    logic [35:0]       wrOld;
    logic              addrPhase;
    logic [1:0]        rdSel;

    logic [35:0] memArr [DEPTH];

    // ****************************************
    // input side
    // ****************************************
    // undriven mask use: every lane enabled, strobe alone decides
    assign maskIn = s_r.maskUse ? byteMask : MASK_ALL; // see R05

    erbw_in_regs #(
        .ADDR_W (ADDR_W)
    ) u_in (
        .clk      (clk),
        .nrst     (nrst),
        .clkEn    (portClkEn),
        .wrStrobe (wrStrobe),
        .wrAddr   (wrAddr),
        .wrData   (wrData),
        .maskIn   (maskIn),
        .rdStrobe (rdStrobe),
        .rdAddr   (rdAddr),
        .wrEnQ    (wrEnQ),
        .wrAddrQ  (wrAddrQ),
        .wrDataQ  (wrDataQ),
        .maskQ    (maskQ),
        .rdEnQ    (rdEnQ),
        .rdAddrQ  (rdAddrQ)
    );

    erbw_lane_decode u_dec (
        .mode  (s_r.mode),
        .mask  (maskQ),
        .wrEn  (wrEnQ),
        .bitEn (bitEn)
    );

    // ****************************************
    // array
    // ****************************************
    // only enabled bits change; the ninth bit of a lane is plain data
    always_ff @(posedge clk) begin
        if (portClkEn && (|bitEn)) begin // see R01
            memArr[wrAddrQ] <= (memArr[wrAddrQ] & ~bitEn) | (wrDataQ & bitEn); // see R03 see R04
        end
    end

    // reads see the word before a same-edge write
    assign memRd = memArr[rdAddrQ];
    assign wrOld = memArr[wrAddrQ];

    // ****************************************
    // bus decode
    // ****************************************
    assign addrPhase = hsel && htrans[1] && hready;

    // register select from the full byte address
    always_comb begin
        if (haddr == REG_CTRL) begin
            rdSel = SEL_CTRL;
        end else if (haddr == REG_STATUS) begin
            rdSel = SEL_STATUS;
        end else begin
            rdSel = SEL_NONE;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt           = s_r;
        s_nxt.hreadyout = 1'b1;
        s_nxt.wrPend    = 1'b0;
        // data phase of a write: store into control
        if (s_r.wrPend && s_r.wrSel == SEL_CTRL) begin
            s_nxt.mode    = erbw_width_t'(hwdata[CTRL_MODE_POS +: 3]);
            s_nxt.maskUse = hwdata[CTRL_MUSE_POS];
        end
        // address phase: note writes, prepare read data
        if (addrPhase) begin
            if (hwrite) begin
                s_nxt.wrPend = 1'b1;
                s_nxt.wrSel  = rdSel;
            end else if (rdSel == SEL_CTRL) begin
                s_nxt.hrdata = {28'h000_0000, s_r.maskUse, s_r.mode};
            end else if (rdSel == SEL_STATUS) begin
                s_nxt.hrdata = {s_r.rdCount, s_r.wrCount};
            end else begin
                s_nxt.hrdata = 32'h0000_0000;
            end
        end
        // ram port: nothing moves without the clock enable
        if (portClkEn) begin // see R01
            if (rdEnQ) begin // see R12
                s_nxt.rdData  = memRd & erbw_width_bits(s_r.mode);
                s_nxt.rdCount = 16'(s_r.rdCount + 16'h0001);
            end
            if (wrEnQ) begin
                s_nxt.wrCount = 16'(s_r.wrCount + 16'h0001);
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r           <= '0;
            s_r.mode      <= CTRL_MODE_RST;
            s_r.maskUse   <= CTRL_MUSE_RST;
            s_r.hreadyout <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = s_r.hreadyout;
    assign hresp     = 1'b0;
    assign hrdata    = s_r.hrdata;
    assign rdData    = s_r.rdData;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_wr_edge;
        portClkEn && (|bitEn);
    endsequence

    sequence s_rd_edge;
        portClkEn && rdEnQ;
    endsequence

    // a write strobe offered on an enabled edge
    sequence s_wr_req;
        portClkEn && wrStrobe;
    endsequence

    // that request, then the enabled edge on which it takes effect
    sequence s_wr_follow;
        s_wr_req ##1 portClkEn;
    endsequence

    // a control write, then its data phase
    sequence s_ctrl_wr;
        (addrPhase && hwrite && rdSel == SEL_CTRL) ##1 1'b1;
    endsequence

    a_clken_freeze: assert property (!portClkEn |=> $stable(rdData) && $stable(s_r.wrCount)
        && (memArr[$past(wrAddrQ)] == $past(wrOld))) // see R01
        else $error("state moved while clock enable low");

    a_read_hold: assert property (portClkEn && !rdEnQ |=> $stable(rdData)) // see R12
        else $error("read data changed without read strobe");

    a_read_fetch: assert property (s_rd_edge |=>
        rdData == ($past(memRd) & erbw_width_bits(s_r.mode))
        && s_r.rdCount == 16'($past(s_r.rdCount) + 16'h0001)) // see R02
        else $error("read did not fetch addressed word");

    a_lane_keep: assert property (s_wr_edge |=>
        ((memArr[$past(wrAddrQ)] ^ $past(wrOld)) & ~$past(bitEn)) == 36'h0_0000_0000) // see R04
        else $error("unselected lane altered");

    a_lane_write: assert property (s_wr_edge |=>
        ((memArr[$past(wrAddrQ)] ^ $past(wrDataQ)) & $past(bitEn)) == 36'h0_0000_0000) // see R05
        else $error("selected lane not written");

    a_mask_default: assert property (portClkEn && !s_r.maskUse |=> maskQ == MASK_ALL) // see R05
        else $error("default mask not all ones");

    a_narrow_nomask: assert property (wrEnQ && (s_r.mode == WID8 || s_r.mode == WID9)
        |-> bitEn == erbw_width_bits(s_r.mode)) // see R07
        else $error("narrow width used the mask");

    a_lane18_low: assert property ((s_wr_edge and (s_r.mode == WID18 && maskQ[1:0] == 2'h1))
        |=>
        memArr[$past(wrAddrQ)][17:9] == $past(wrOld[17:9])
        && memArr[$past(wrAddrQ)][8:0] == $past(wrDataQ[8:0])) // see R09
        else $error("18-bit low lane write wrong");

    a_lane36_high: assert property (wrEnQ && s_r.mode == WID36 |->
        bitEn[35:27] == {9{maskQ[3]}} && bitEn[26:18] == {9{maskQ[2]}}
        && bitEn[8:0] == {9{maskQ[0]}}) // see R10 see R08
        else $error("36-bit lane map wrong");

    a_lane_indep: assert property (wrEnQ && s_r.mode == WID32 |->
        $countones(bitEn) == 8 * $countones(maskQ)) // see R11
        else $error("32-bit lanes not independent");

    a_ninth_bit: assert property ((s_wr_edge and (s_r.mode == WID36 && maskQ[0])) |=>
        memArr[$past(wrAddrQ)][8] == $past(wrDataQ[8])) // see R03
        else $error("extra bit not stored as data");

    // ****************************************
    // further checks
    // ****************************************
    // a strobe captured on one enabled edge is counted on the next
    a_wr_count: assert property (s_wr_follow |=> // see R02
        s_r.wrCount == 16'($past(s_r.wrCount) + 16'h0001))
        else $error("write strobe not counted");

    // a frozen edge captures nothing at all
    a_no_capture: assert property (!portClkEn |=> $stable(wrEnQ) && $stable(rdEnQ) // see R01
        && $stable(wrAddrQ) && $stable(rdAddrQ) && $stable(wrDataQ))
        else $error("input captured while clock enable low");

    // no strobe, no bit enable
    a_strobe_gate: assert property (!wrEnQ |-> bitEn == 36'h0_0000_0000) // see R05
        else $error("bit enable without write strobe");

    // 16-bit lanes are the two low bytes
    a_lane16_map: assert property (wrEnQ && s_r.mode == WID16 |-> // see R10 see R08
        bitEn[35:16] == 20'h0_0000 && bitEn[15:8] == {8{maskQ[1]}}
        && bitEn[7:0] == {8{maskQ[0]}})
        else $error("16-bit lane map wrong");

    // 18-bit lanes are nine bits each
    a_lane18_map: assert property (wrEnQ && s_r.mode == WID18 |-> // see R09
        bitEn[35:18] == 18'h0_0000 && bitEn[17:9] == {9{maskQ[1]}}
        && bitEn[8:0] == {9{maskQ[0]}})
        else $error("18-bit lane map wrong");

    // 32-bit lanes: the two high bytes follow mask bits 3 and 2, the top four bits stay unwritten
    a_lane32_map: assert property (wrEnQ && s_r.mode == WID32 |-> // see R10
        bitEn[35:32] == 4'h0 && bitEn[31:24] == {8{maskQ[3]}}
        && bitEn[23:16] == {8{maskQ[2]}})
        else $error("32-bit lane map wrong");

    // control takes the width and mask use of its data phase
    a_ctrl_store: assert property (s_ctrl_wr |=> // see R07
        s_r.mode == erbw_width_t'($past(hwdata[CTRL_MODE_POS +: 3]))
        && s_r.maskUse == $past(hwdata[CTRL_MUSE_POS]))
        else $error("control write not stored");

endmodule

// >>> src/erbw_pkg.sv
// constants, types and lane functions of the byte-write ram port
// ****************************************
// How it works
// R01 - clock enable low freezes every register (the ahb-side control and bus registers still update)
// R02 - separate read and write strobes per port
// R03 - ninth bit per byte stored as data
// R04 - unselected lanes keep their old value
// R05 - lane written needs strobe and mask bit
// R06 - mask registers have no clear
// R07 - masking only at widths 16/18/32/36
// R08 - mask bit 0 selects lowest byte
// R09 - 18-bit lanes are bits 8:0, 17:9
// R10 - 8-bit lanes at 16/32, 9-bit at 36
// R11 - any mask combination, lanes independent
// R12 - read strobe low holds read data
// ****************************************
package erbw_pkg;

    // write width modes of the port
    typedef enum logic [2:0] {WID8, WID9, WID16, WID18, WID32, WID36} erbw_width_t;

    localparam int          DATA_W         = 36;
    localparam int          LANES          = 4;
    localparam int          DEPTH_DEF      = 256;
    localparam logic [3:0]  MASK_ALL       = 4'hF;

    // register map and fields
    localparam logic [31:0] REG_CTRL       = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS     = 32'h0000_0004;
    localparam int          CTRL_MODE_POS  = 0;
    localparam int          CTRL_MUSE_POS  = 3;
    localparam int          STAT_WR_POS    = 0;
    localparam int          STAT_RD_POS    = 16;
    localparam erbw_width_t CTRL_MODE_RST  = WID36;
    localparam logic        CTRL_MUSE_RST  = 1'b0;
    localparam logic [1:0]  SEL_NONE       = 2'h0;
    localparam logic [1:0]  SEL_CTRL       = 2'h1;
    localparam logic [1:0]  SEL_STATUS     = 2'h2;

    // bits that a mode carries on the data bus
    function automatic logic [35:0] erbw_width_bits(input erbw_width_t m);
        logic [35:0] b;
        b = 36'h0_0000_0000;
        case (m)
            WID8:    b = 36'h0_0000_00FF;
            WID9:    b = 36'h0_0000_01FF;
            WID16:   b = 36'h0_0000_FFFF;
            WID18:   b = 36'h0_0003_FFFF;
            WID32:   b = 36'h0_FFFF_FFFF;
            WID36:   b = 36'hF_FFFF_FFFF;
            default: b = 36'h0_0000_0000;
        endcase
        return b;
    endfunction

    // per-bit write enable from mode and lane mask
    function automatic logic [35:0] erbw_lane_bits(input erbw_width_t m, input logic [3:0] k);
        logic [35:0] b;
        b = 36'h0_0000_0000;
        case (m)
            WID16:   b = {20'h0_0000, {8{k[1]}}, {8{k[0]}}};
            WID18:   b = {18'h0_0000, {9{k[1]}}, {9{k[0]}}};
            WID32:   b = {4'h0, {8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
            WID36:   b = {{9{k[3]}}, {9{k[2]}}, {9{k[1]}}, {9{k[0]}}};
            default: b = erbw_width_bits(m);
        endcase
        return b;
    endfunction

endpackage

// >>> src/erbw_lane_decode.sv
// lane decode: turns mode, mask and write strobe into bit enables
`timescale 1ns/1ns
module erbw_lane_decode (
    input  wire erbw_pkg::erbw_width_t mode,
    input  wire logic [3:0]            mask,
    input  wire logic                  wrEn,
    output logic [35:0]                bitEn
);
    import erbw_pkg::*;

    // ****************************************
    // decode
    // ****************************************
    // narrow modes ignore the mask; lane k follows mask bit k
    always_comb begin
        bitEn = wrEn ? erbw_lane_bits(mode, mask) : 36'h0_0000_0000; // see R05 see R07 see R08
    end

endmodule

// >>> src/erbw_in_regs.sv
// input registers of the port: strobes, addresses, data and lane mask
`timescale 1ns/1ns
module erbw_in_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic              wrStrobe,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [35:0]       wrData,
    input  wire logic [3:0]        maskIn,
    input  wire logic              rdStrobe,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic                   wrEnQ,
    output logic [ADDR_W-1:0]      wrAddrQ,
    output logic [35:0]            wrDataQ,
    output logic [3:0]             maskQ,
    output logic                   rdEnQ,
    output logic [ADDR_W-1:0]      rdAddrQ
);
    import erbw_pkg::*;

    typedef struct packed {
        logic              wrEn;
        logic [ADDR_W-1:0] wrAddr;
        logic [35:0]       wrData;
        logic              rdEn;
        logic [ADDR_W-1:0] rdAddr;
    } erbw_in_t;

    erbw_in_t s_r;
    erbw_in_t s_nxt;
    logic [3:0] mask_r;

    // ****************************************
    // capture
    // ****************************************
    // capture only on enabled edges, otherwise hold
    always_comb begin
        s_nxt = s_r;
        if (clkEn) begin // see R01
            s_nxt.wrEn   = wrStrobe; // see R02
            s_nxt.wrAddr = wrAddr;
            s_nxt.wrData = wrData;
            s_nxt.rdEn   = rdStrobe; // see R02
            s_nxt.rdAddr = rdAddr;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // mask register has no clear; reset leaves it alone
    always_ff @(posedge clk) begin
        if (clkEn) begin // see R06
            mask_r <= maskIn;
        end
    end

    assign wrEnQ   = s_r.wrEn;
    assign wrAddrQ = s_r.wrAddr;
    assign wrDataQ = s_r.wrData;
    assign rdEnQ   = s_r.rdEn;
    assign rdAddrQ = s_r.rdAddr;
    assign maskQ   = mask_r;

    a_mask_noclear: assert property (@(posedge clk) !$past(clkEn) |-> $stable(mask_r)) // see R06
        else $error("mask register changed without enabled edge");

endmodule

// >>> bench/erbw_fabric.sv
// user fabric model that drives the ram port of the byte-write block
`timescale 1ns/1ns
module erbw_fabric #(
    parameter int AW = 4
) (
    input  wire logic     clk,
    output logic          portClkEn,
    output logic          wrStrobe,
    output logic [AW-1:0] wrAddr,
    output logic [35:0]   wrData,
    output logic [3:0]    byteMask,
    output logic          rdStrobe,
    output logic [AW-1:0] rdAddr
);
    // ****************************************
    // port driver
    // ****************************************
    // idle values from time zero; clock enable idles high so the mask
    // register, which has no clear, loads a known value while reset is held
    initial begin
        portClkEn = 1'b1;
        wrStrobe  = 1'b0;
        wrAddr    = '0;
        wrData    = 36'h0_0000_0000;
        byteMask  = 4'hF;
        rdStrobe  = 1'b0;
        rdAddr    = '0;
    end

    // request on one edge, strobes dropped after it, result lands one edge later
    task automatic access(input logic en, input logic we, input logic [AW-1:0] wa,
                          input logic [35:0] wd, input logic [3:0] m, input logic re,
                          input logic [AW-1:0] ra);
        @(posedge clk);
        portClkEn <= en;
        wrStrobe  <= we;
        wrAddr    <= wa;
        wrData    <= wd;
        byteMask  <= m;
        rdStrobe  <= re;
        rdAddr    <= ra;
        @(posedge clk);
        wrStrobe  <= 1'b0;
        rdStrobe  <= 1'b0;
        wrData    <= ~wd;   // released lines show no stale value
        byteMask  <= ~m;
        wrAddr    <= ~wa;
        rdAddr    <= ~ra;
        @(posedge clk);
        #1;
    endtask
endmodule

// >>> bench/erbw_ram_tb.sv
// self-checking bench of the byte-write ram port
`timescale 1ns/1ns
module erbw_ram_tb;
    import erbw_pkg::*;
    logic        clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic        portClkEn, wrStrobe, rdStrobe;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  wrAddr, rdAddr, byteMask;
    logic [35:0] wrData, rdData, hold;
    logic [35:0] mem [16];
    logic [3:0]  masks [4] = '{4'b0101, 4'b1010, 4'b0000, 4'b0001};
    int          errorCnt, nTests, nWr, nRd, md;
    logic        mUse;

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    erbw_ram #(.DEPTH(16)) u_erbw_ram (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .portClkEn(portClkEn),
        .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData), .byteMask(byteMask),
        .rdStrobe(rdStrobe), .rdAddr(rdAddr), .rdData(rdData));

    erbw_fabric #(.AW(4)) u_erbw_fabric (
        .clk(clk), .portClkEn(portClkEn), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
        .wrData(wrData), .byteMask(byteMask), .rdStrobe(rdStrobe), .rdAddr(rdAddr));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bounded wait for hready at a rising edge
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            errorCnt++;
            $display("MISMATCH at %0t: bus wait ran out", $time);
            printVerdict();
        end
    endtask

    // one single ahb transfer; read data left in rdv
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitReady();
        rdv = hrdata;
    endtask

    // expected bit enables from mode and lane mask
    function automatic logic [35:0] laneEn(input int m, input logic [3:0] k);
        case (m)
            0: return 36'h0_0000_00FF;
            1: return 36'h0_0000_01FF;
            2: return {20'h0_0000, {8{k[1]}}, {8{k[0]}}};
            3: return {18'h0_0000, {9{k[1]}}, {9{k[0]}}};
            4: return {4'h0, {8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
            default: return {{9{k[3]}}, {9{k[2]}}, {9{k[1]}}, {9{k[0]}}};
        endcase
    endfunction

    task automatic setMode(input int m, input logic u);
        md   = m;
        mUse = u;
        ahb(1'b1, REG_CTRL, {28'h000_0000, u, 3'(m)});
        ahb(1'b0, REG_CTRL, 32'h0000_0000);
        check({4'h0, rdv}, {32'h0000_0000, u, 3'(m)}, "ctrl readback");
    endtask

    // port write that also updates the expected array
    task automatic pw(input int a, input logic [35:0] d, input logic [3:0] k);
        logic [35:0] en;
        u_erbw_fabric.access(1'b1, 1'b1, 4'(a), d, k, 1'b0, 4'h0);
        en = laneEn(md, mUse ? k : 4'hF);
        mem[a] = (mem[a] & ~en) | (d & en);
        nWr++;
    endtask

    task automatic pr(input int a);
        u_erbw_fabric.access(1'b1, 1'b0, 4'h0, 36'h0_0000_0000, 4'hF, 1'b1, 4'(a));
        nRd++;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        errorCnt = 0;
        nTests = 0;
        nWr = 0;
        nRd = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        ahb(1'b0, REG_CTRL, 32'h0000_0000);
        check({4'h0, rdv}, 36'h0_0000_0005, "ctrl reset");
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        check({4'h0, rdv}, 36'h0_0000_0000, "unmapped read");
        check(rdData, 36'h0_0000_0000, "read data reset");
        check({35'h0, hresp}, 36'h0_0000_0000, "okay response");
        $display("test reset done");
        // full words with the ninth bit of every byte set, every location,
        // so that no later check meets an unwritten word
        md = 5;
        mUse = 1'b0;
        for (int a = 0; a < 16; a++) begin
            pw(a, 36'h8_0402_0100 + 36'(a * 3), 4'h0);
            pr(a);
            check(rdData, mem[a], "ninth bits kept");
        end
        $display("test full words done");
        // every masked width with mixed and sparse masks
        for (int m = 2; m < 6; m++) begin
            setMode(m, 1'b1);
            foreach (masks[i]) begin
                pw(1, 36'h6_3C96_C3A5 ^ {9{4'(i + m)}}, masks[i]);
                pr(1);
                check(rdData, mem[1] & laneEn(md, 4'hF), "masked lanes");
            end
        end
        // widths without masking write all 8 or 9 of their bits whatever the mask
        for (int m = 0; m < 2; m++) begin
            setMode(m, 1'b1);
            pw(2, 36'h3_1234_5678 + 36'(m), 4'h0);
            pr(2);
            check(rdData, mem[2] & laneEn(md, 4'hF), "mask ignored");
        end
        $display("test lane masks done");
        // undriven mask: strobe alone writes
        setMode(5, 1'b0);
        pw(3, 36'hC_0FF0_0FF0, 4'h0);
        pr(3);
        check(rdData, mem[3], "default mask");
        // clock enable low blocks both write and read
        pr(0);
        hold = mem[0];
        u_erbw_fabric.access(1'b0, 1'b1, 4'h3, 36'h0_0000_0000, 4'hF, 1'b1, 4'h3);
        check(rdData, hold, "frozen read");
        pr(3);
        check(rdData, mem[3], "frozen write");
        // strobes low: no write and read data held
        hold = mem[3];
        u_erbw_fabric.access(1'b1, 1'b0, 4'h3, 36'h0_0000_0000, 4'hF, 1'b0, 4'h0);
        check(rdData, hold, "read strobe low");
        pr(3);
        check(rdData, mem[3], "write strobe low");
        ahb(1'b0, REG_STATUS, 32'h0000_0000);
        check({4'h0, rdv}, {4'h0, 16'(nRd), 16'(nWr)}, "strobe counts");
        $display("test enables done");
        // reset in mid-run: control, counters and read data return to reset values
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        ahb(1'b0, REG_CTRL, 32'h0000_0000);
        check({4'h0, rdv}, 36'h0_0000_0005, "ctrl after reset");
        ahb(1'b0, REG_STATUS, 32'h0000_0000);
        check({4'h0, rdv}, 36'h0_0000_0000, "counts after reset");
        check(rdData, 36'h0_0000_0000, "read data after reset");
        pr(3);
        check(rdData, mem[3], "array kept over reset");
        $display("test mid-run reset done");
        printVerdict();
    end
endmodule
